// file: dv/eeprom_front_end_chk.sv
`timescale 1ns/1ns
`default_nettype none

// Pin-level checks of the front end, all in the system clock domain
module eeprom_front_end_chk (
  input wire logic I_CLOCK,
  input wire logic I_RST_B,
  input wire logic I_SCL,
  input wire logic I_WRITE_PROTECT_IN,
  input wire logic I_WRITE_BUSY,
  input wire logic O_SDA_OUT,
  input wire logic O_SDA_OE,
  input wire logic O_ADDR_VALID,
  input wire logic O_DATA_VALID,
  input wire logic O_READ_REQ,
  input wire logic O_WRITE_START,
  input wire logic O_STANDBY
);
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_B);

  // Open drain: only a low level may ever be driven, and pulling may only begin in the clock low phase
  sda_low_only_a: assert property (O_SDA_OUT == 1'b0)
    else $error("data line driven high");
  ack_in_low_a: assert property ($rose(O_SDA_OE) |-> !I_SCL)
    else $error("data line pulled while clock high");
  // Address and read strobes last one cycle
  addr_pulse_a: assert property (O_ADDR_VALID |=> !O_ADDR_VALID)
    else $error("address strobe too long");
  read_pulse_a: assert property (O_READ_REQ |=> !O_READ_REQ)
    else $error("read request too long");
  // Protected data is never strobed to the core; protect passes a two-stage synchroniser
  wp_blocks_data_a: assert property (O_DATA_VALID |-> !$past(I_WRITE_PROTECT_IN, 3))
    else $error("data passed while protected");
  // Standby and quiet bus
  busy_no_stby_a: assert property (I_WRITE_BUSY [*2] |-> !O_STANDBY)
    else $error("standby during internal write");
  write_stby_a: assert property (O_WRITE_START |-> ##[0:3] O_STANDBY)
    else $error("no standby after write trigger");
  stby_quiet_a: assert property (O_STANDBY |-> !O_SDA_OE)
    else $error("data line pulled in standby");
  reset_quiet_a: assert property ($rose(I_RST_B) |-> O_STANDBY && !O_SDA_OE)
    else $error("not in standby after reset");
endmodule : eeprom_front_end_chk

bind eeprom_front_end eeprom_front_end_chk i_eeprom_front_end_chk (
  .I_CLOCK(I_CLOCK), .I_RST_B(I_RST_B), .I_SCL(I_SCL),
  .I_WRITE_PROTECT_IN(I_WRITE_PROTECT_IN), .I_WRITE_BUSY(I_WRITE_BUSY),
  .O_SDA_OUT(O_SDA_OUT), .O_SDA_OE(O_SDA_OE), .O_ADDR_VALID(O_ADDR_VALID),
  .O_DATA_VALID(O_DATA_VALID), .O_READ_REQ(O_READ_REQ),
  .O_WRITE_START(O_WRITE_START), .O_STANDBY(O_STANDBY));

`default_nettype wire

// file: dv/tb_eeprom_front_end.sv
`timescale 1ns/1ns
`default_nettype none

// Self-checking bench for the two-wire front end
module tb_eeprom_front_end;
  localparam logic [3:0] TYPE_ID = 4'h6; // Arbitrary value
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic        busy  = 1'b0;
  logic        wp    = 1'b0;
  logic [2:0]  strap = 3'h0;
  logic [7:0]  rd_data = 8'h00;
  logic        scl, m_oe, sda_oe, sda_out, addr_v, data_v, rd_req, wr_start, standby;
  logic [15:0] addr;
  logic [7:0]  data;
  int          miscompares = 0;
  int          tests_run = 0;
  int          cycles = 0;
  int          n_wr = 0;
  int          n_dv = 0;
  int          n_av = 0;
  // Pull-up wins unless some party pulls low; the device shows its output level when enabled
  wire logic   sda = ~m_oe & ~(sda_oe & ~sda_out);

  always #5 clock = ~clock;

  // Core stand-in: counts write triggers, answers read requests one cycle later
  always @(posedge clock) begin
    cycles++;
    if (wr_start) n_wr <= n_wr + 1;
    if (data_v) n_dv <= n_dv + 1;
    if (addr_v) n_av <= n_av + 1;
    if (rd_req) rd_data <= #1 rd_data + 8'h3B;
    if (cycles == 20000) begin
      miscompares++;
      results();
    end
  end

  two_wire_master master (.i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));

  eeprom_front_end #(.DEV_TYPE_ID(TYPE_ID)) i_eeprom_front_end (
    .I_CLOCK(clock), .I_RST_B(rst_b), .I_SCL(scl), .I_SDA(sda),
    .O_SDA_OUT(sda_out), .O_SDA_OE(sda_oe), .I_CHIP_ADDR_STRAP0(strap[0]),
    .I_CHIP_ADDR_STRAP1(strap[1]), .I_CHIP_ADDR_STRAP2(strap[2]),
    .I_WRITE_PROTECT_IN(wp), .I_WRITE_BUSY(busy), .I_READ_DATA(rd_data),
    .O_ADDR(addr), .O_ADDR_VALID(addr_v), .O_DATA(data), .O_DATA_VALID(data_v),
    .O_READ_REQ(rd_req), .O_WRITE_START(wr_start), .O_STANDBY(standby));

  task automatic check(input logic ok, input string what);
    tests_run++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask : check

  task automatic results();
    $display("checks %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results

  function automatic logic [7:0] sel(input logic [2:0] c, input logic rw);
    return {TYPE_ID, c, rw};
  endfunction : sel

  // Byte write; protected data gets no ack and no write cycle
  task automatic t_write(input logic prot);
    logic ack;
    int   wr0;
    int   dv0;
    int   av0;
    @(posedge clock) #1 wp = prot;
    wr0 = n_wr;
    dv0 = n_dv;
    av0 = n_av;
    master.start_cond();
    master.send_byte(sel(strap, 1'b0), ack);
    check(ack === 1'b1, "select ack");
    master.send_byte(8'hA5, ack);
    check(ack === 1'b1, "upper address ack");
    master.send_byte(8'h3C, ack);
    check(ack === 1'b1 && addr === 16'hA53C, "address");
    check(n_av === av0 + 1, "address strobe");
    master.send_byte(8'h96, ack);
    check(ack === ~prot, "data ack");
    check(prot || data === 8'h96, "data byte");
    check(n_dv === dv0 + (prot ? 0 : 1), "data strobe");
    master.stop_cond();
    repeat (8) @(posedge clock);
    check(n_wr === wr0 + (prot ? 0 : 1) && standby === 1'b1, "write trigger");
    master.start_cond();
    master.send_byte(sel(strap, 1'b0), ack);
    master.send_byte(8'h01, ack);
    master.stop_cond();
    repeat (8) @(posedge clock);
    check(n_wr === wr0 + (prot ? 0 : 1), "early stop wrote");
  endtask : t_write

  // Every strap setting; a neighbour address and a wrong type are ignored
  task automatic t_straps();
    logic ack;
    for (int s = 0; s < 8; s++) begin
      @(posedge clock) #1 strap = 3'(s);
      master.start_cond();
      master.send_byte(sel(3'(s), 1'b0), ack);
      check(ack === 1'b1, "strap match");
      master.start_cond();
      master.send_byte(sel(3'(s) ^ (3'h1 << (s % 3)), 1'b0), ack);
      check(ack === 1'b0, "strap mismatch acked");
      master.send_byte(8'h00, ack);
      check(ack === 1'b0, "ignored byte acked");
      master.stop_cond();
    end
    master.start_cond();
    master.send_byte({~TYPE_ID, strap, 1'b0}, ack);
    check(ack === 1'b0, "wrong type acked");
    master.stop_cond();
  endtask : t_straps

  // Two-byte read; master acks the first, refuses the second
  task automatic t_read();
    logic       ack;
    logic [7:0] d;
    master.start_cond();
    master.send_byte(sel(strap, 1'b1), ack);
    check(ack === 1'b1, "read select");
    master.get_byte(d, 1'b1);
    check(d === 8'h3B, "first read byte");
    master.get_byte(d, 1'b0);
    check(d === 8'h76, "second read byte");
    master.stop_cond();
    repeat (8) @(posedge clock);
    check(standby === 1'b1, "standby after read");
  endtask : t_read

  // Internal write running, then reset in mid-command, then recovery
  task automatic t_busy_reset();
    logic ack;
    @(posedge clock) #1 busy = 1'b1;
    master.start_cond();
    master.send_byte(sel(strap, 1'b0), ack);
    check(ack === 1'b0 && standby === 1'b0, "busy select");
    master.stop_cond();
    @(posedge clock) #1 busy = 1'b0;
    master.start_cond();
    master.send_byte(sel(strap, 1'b0), ack);
    @(posedge clock) #1 rst_b = 1'b0;
    master.send_byte(8'h12, ack);
    check(ack === 1'b0 && standby === 1'b1, "ack in reset");
    master.stop_cond();
    @(posedge clock) #1 rst_b = 1'b1;
    repeat (4) @(posedge clock);
    master.start_cond();
    master.send_byte(sel(strap, 1'b0), ack);
    check(ack === 1'b1, "select after reset");
    master.stop_cond();
  endtask : t_busy_reset

  // Main sequence
  initial begin
    repeat (10) @(posedge clock);
    #1 rst_b = 1'b1;
    repeat (4) @(posedge clock);
    t_write(1'b0);
    t_write(1'b1);
    t_straps();
    t_read();
    t_busy_reset();
    results();
  end
endmodule : tb_eeprom_front_end

`default_nettype wire

// file: dv/two_wire_master.sv
`timescale 1ns/1ns
`default_nettype none

// Bus master model; the clock stands high between frames, each phase lasts two link ticks
module two_wire_master (
  input  wire logic i_sda,
  output var  logic o_scl,
  output var  logic o_sda_oe
);
  logic tick = 1'b0;

  // 32 ns link tick, phase unrelated to the system clock
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
    #7;
    forever #16 tick = ~tick;
  end

  // One clock pulse; data changes only in the low phase, sampled mid high phase
  task automatic clk_bit(input logic drive, output logic got);
    o_sda_oe = ~drive;
    @(posedge tick);
    o_scl = 1'b1;
    @(posedge tick);
    got = i_sda;
    @(posedge tick);
    o_scl = 1'b0;
    @(posedge tick);
  endtask : clk_bit

  // Start from idle or as a repeated start
  task automatic start_cond();
    o_sda_oe = 1'b0;
    @(posedge tick);
    o_scl = 1'b1;
    @(posedge tick);
    o_sda_oe = 1'b1;
    @(posedge tick);
    o_scl = 1'b0;
    @(posedge tick);
  endtask : start_cond

  task automatic stop_cond();
    o_sda_oe = 1'b1;
    @(posedge tick);
    o_scl = 1'b1;
    @(posedge tick);
    o_sda_oe = 1'b0;
    repeat (2) @(posedge tick);
  endtask : stop_cond

  // Byte out MSB first, then release for the ninth pulse
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic n;
    for (int i = 7; i >= 0; i--) clk_bit(b[i], n);
    clk_bit(1'b1, n);
    ack = ~n;
  endtask : send_byte

  task automatic get_byte(output logic [7:0] d, input logic ack);
    logic n;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
    clk_bit(~ack, n);
  endtask : get_byte
endmodule : two_wire_master

`default_nettype wire

// file: verilog/eeprom_front_end.sv
`timescale 1ns/1ns
`default_nettype none

// Function
// - Serial clock from master strobes all data
// - Device is slave; master starts every transfer
// - Data line driven open-drain only
// - Start is data fall with clock high
// - Starts watched always except during write
// - Stop is data rise with clock high
// - Stop after read no-ack gives standby
// - Stop ending write command starts write
// - Transmitter releases data after eight bits
// - Receiver pulls data low in ninth clock
// - Select byte MSB first: type, chip, rw
// - Straps give expected chip address bits
// - Respond only if all three bits match
// - Unconnected straps read as zero
// - Write protect high blocks all writes
// - Unconnected write protect reads as low
// - Protected: ack select/address, not data
// - Address is upper byte plus lower byte
// - Reset release gives standby, ignore before
// - Reset active again stops all responses
// - Stop gives standby when no write running
// - Data sampled on rising serial clock
// - Flag one is read, zero is write
// - Mismatch: no ack, release, standby; code holds ST_IGNORE with O_STANDBY low until a stop or a new start
// - Upper address byte comes first
module eeprom_front_end #(
  parameter logic [3:0] DEV_TYPE_ID = 4'h6  // Arbitrary value, set per product
) (
  input  wire logic        I_CLOCK,
  input  wire logic        I_RST_B,
  input  wire logic        I_SCL,
  input  wire logic        I_SDA,
  output var  logic        O_SDA_OUT,
  output var  logic        O_SDA_OE,
  input  wire logic        I_CHIP_ADDR_STRAP0,
  input  wire logic        I_CHIP_ADDR_STRAP1,
  input  wire logic        I_CHIP_ADDR_STRAP2,
  input  wire logic        I_WRITE_PROTECT_IN,
  input  wire logic        I_WRITE_BUSY,
  input  wire logic [7:0]  I_READ_DATA,
  output var  logic [15:0] O_ADDR,
  output var  logic        O_ADDR_VALID,
  output var  logic [7:0]  O_DATA,
  output var  logic        O_DATA_VALID,
  output var  logic        O_READ_REQ,
  output var  logic        O_WRITE_START,
  output var  logic        O_STANDBY
);

  // Link domain: bit sampler on the master's serial clock
  logic                   link_bit_reg;
  logic                   link_tgl_reg;

  // System domain synchronisers
  logic                   tgl_s1_reg;
  logic                   tgl_s2_reg;
  logic                   tgl_s3_reg;
  logic                   scl_s1_reg;
  logic                   scl_s2_reg;
  logic                   scl_s3_reg;
  logic                   sda_s1_reg;
  logic                   sda_s2_reg;
  logic                   sda_s3_reg;
  logic [3:0]             pin_s1_reg;
  logic [3:0]             pin_s2_reg;

  // Protocol state
  eeprom_front_end_pkg::bus_state_type state_reg;
  eeprom_front_end_pkg::bus_state_type state_next;
  logic [3:0]             cnt_reg;
  logic [3:0]             cnt_next;
  logic [7:0]             shift_reg;
  logic [7:0]             tx_reg;
  logic [7:0]             addr_hi_reg;
  logic                   ack_reg;
  logic                   ack_next;
  logic                   wr_slot_reg;
  logic                   load_reg;
  logic                   oe_reg;
  logic                   oe_next;

  // Decoded events and fields
  wire logic              rise_ev;
  wire logic              fall_ev;
  wire logic              start_ev;
  wire logic              stop_ev;
  wire logic              byte_done;
  wire logic              ack_rise;
  wire logic [7:0]        rx_byte;
  wire logic [2:0]        strap_addr;
  wire logic              protect;
  wire logic              sel_match;
  wire logic              active;
  wire logic              tx_bit;

  // Index of the bit being sent, MSB first
  function automatic logic pick_bit(input logic [7:0] b, input logic [3:0] n);
    logic [2:0] idx;
    idx = 3'h7 - n[2:0];
    return b[idx];
  endfunction : pick_bit

  // Master owns the clock; the device only samples on its rising edge
  always_ff @(posedge I_SCL or negedge I_RST_B) begin
    if (!I_RST_B) begin
      link_bit_reg <= 1'b0;
      link_tgl_reg <= 1'b0;
    end else begin
      link_bit_reg <= I_SDA;
      link_tgl_reg <= ~link_tgl_reg;
    end
  end

  // Toggle crossing: the sampled bit holds until the next clock rise
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      tgl_s1_reg <= 1'b0;
      tgl_s2_reg <= 1'b0;
      tgl_s3_reg <= 1'b0;
    end else begin
      tgl_s1_reg <= link_tgl_reg;
      tgl_s2_reg <= tgl_s1_reg;
      tgl_s3_reg <= tgl_s2_reg;
    end
  end

  // Bus lines, idle high, through three stages; strap and protect pins through two
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      scl_s3_reg <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      sda_s3_reg <= 1'b1;
      pin_s1_reg <= 4'h0;
      pin_s2_reg <= 4'h0;
    end else begin
      scl_s1_reg <= I_SCL;
      scl_s2_reg <= scl_s1_reg;
      scl_s3_reg <= scl_s2_reg;
      sda_s1_reg <= I_SDA;
      sda_s2_reg <= sda_s1_reg;
      sda_s3_reg <= sda_s2_reg;
      pin_s1_reg <= {I_WRITE_PROTECT_IN, I_CHIP_ADDR_STRAP2, I_CHIP_ADDR_STRAP1,
                     I_CHIP_ADDR_STRAP0};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // Edges and bus conditions decoded from synchronised values; the received byte takes the held link-domain bit
  assign rise_ev   = tgl_s2_reg ^ tgl_s3_reg;
  assign fall_ev   = scl_s3_reg & ~scl_s2_reg;
  assign start_ev  = scl_s2_reg & scl_s3_reg & sda_s3_reg & ~sda_s2_reg;
  assign stop_ev   = scl_s2_reg & scl_s3_reg & ~sda_s3_reg & sda_s2_reg;
  assign byte_done = rise_ev & (cnt_reg == eeprom_front_end_pkg::BIT_LAST_DATA);
  assign ack_rise  = rise_ev & (cnt_reg == eeprom_front_end_pkg::BIT_ACK_SLOT);
  assign rx_byte   = {shift_reg[6:0], link_bit_reg};
  // Floating straps and protect pin rely on pull-downs at the pad
  assign strap_addr = pin_s2_reg[2:0];
  assign protect    = pin_s2_reg[3];
  assign sel_match  = (rx_byte[eeprom_front_end_pkg::SEL_TYPE_MSB:
                               eeprom_front_end_pkg::SEL_TYPE_LSB] == DEV_TYPE_ID) &
                      (rx_byte[eeprom_front_end_pkg::SEL_CHIP_MSB:
                               eeprom_front_end_pkg::SEL_CHIP_LSB] == strap_addr);
  assign active     = (state_reg != eeprom_front_end_pkg::ST_STANDBY) &
                      (state_reg != eeprom_front_end_pkg::ST_IGNORE);
  assign tx_bit     = pick_bit(tx_reg, cnt_reg);

  // Next state: start restarts unless write busy, stop returns to standby, bytes advance
  always_comb begin
    state_next = state_reg;
    ack_next   = ack_reg;
    if (start_ev && !I_WRITE_BUSY) begin
      state_next = eeprom_front_end_pkg::ST_DEVSEL;
      ack_next   = 1'b0;
    end else if (stop_ev) begin
      state_next = eeprom_front_end_pkg::ST_STANDBY;
      ack_next   = 1'b0;
    end else if (byte_done) begin
      case (state_reg)
        eeprom_front_end_pkg::ST_DEVSEL: begin
          // Busy core: no ack, so the master can poll
          ack_next = sel_match & ~I_WRITE_BUSY;
          if (!ack_next) begin
            state_next = eeprom_front_end_pkg::ST_IGNORE;
          end else if (rx_byte[eeprom_front_end_pkg::SEL_RW_BIT] ==
                       eeprom_front_end_pkg::RW_READ) begin
            state_next = eeprom_front_end_pkg::ST_RD_DATA;
          end else begin
            state_next = eeprom_front_end_pkg::ST_ADDR_HI;
          end
        end
        eeprom_front_end_pkg::ST_ADDR_HI: begin
          ack_next   = 1'b1;
          state_next = eeprom_front_end_pkg::ST_ADDR_LO;
        end
        eeprom_front_end_pkg::ST_ADDR_LO: begin
          ack_next   = 1'b1;
          state_next = eeprom_front_end_pkg::ST_WR_DATA;
        end
        eeprom_front_end_pkg::ST_WR_DATA: begin
          ack_next = ~protect;
        end
        eeprom_front_end_pkg::ST_RD_DATA: begin
          ack_next = 1'b0;  // Master acks read bytes
        end
        default: begin
          ack_next = 1'b0;
        end
      endcase
    end else if (ack_rise && state_reg == eeprom_front_end_pkg::ST_RD_DATA &&
                 link_bit_reg) begin
      state_next = eeprom_front_end_pkg::ST_IGNORE;
    end
  end

  // Bit count within a byte; ninth rise wraps to zero
  always_comb begin
    cnt_next = cnt_reg;
    if (start_ev || stop_ev) begin
      cnt_next = eeprom_front_end_pkg::CNT_RESET;
    end else if (rise_ev) begin
      cnt_next = (cnt_reg == eeprom_front_end_pkg::BIT_ACK_SLOT) ?
                 eeprom_front_end_pkg::BIT_FIRST : cnt_reg + 4'h1;
    end
  end

  // Data line is pulled only after clock falls, released at once on start, stop or an inactive state; ack in slot nine, else data or release
  always_comb begin
    oe_next = oe_reg;
    if (!active || start_ev || stop_ev) begin
      oe_next = 1'b0;
    end else if (fall_ev) begin
      if (cnt_reg == eeprom_front_end_pkg::BIT_ACK_SLOT) begin
        oe_next = ack_reg;
      end else if (state_reg == eeprom_front_end_pkg::ST_RD_DATA) begin
        oe_next = ~tx_bit;  // Low bits pull, high bits release
      end else begin
        oe_next = 1'b0;
      end
    end
  end

  // Protocol registers; reset release lands in standby
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      state_reg <= eeprom_front_end_pkg::ST_STANDBY;
      cnt_reg   <= eeprom_front_end_pkg::CNT_RESET;
      ack_reg   <= 1'b0;
      oe_reg    <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      ack_reg   <= ack_next;
      oe_reg    <= oe_next;
    end
  end

  // Receive shifter, MSB first
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      shift_reg <= eeprom_front_end_pkg::BYTE_RESET;
    end else if (rise_ev) begin
      shift_reg <= rx_byte;
    end
  end

  // Two-byte address, upper first, handed to the core
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      addr_hi_reg  <= eeprom_front_end_pkg::BYTE_RESET;
      O_ADDR       <= eeprom_front_end_pkg::ADDR_RESET;
      O_ADDR_VALID <= 1'b0;
    end else begin
      O_ADDR_VALID <= byte_done & (state_reg == eeprom_front_end_pkg::ST_ADDR_LO);
      if (byte_done && state_reg == eeprom_front_end_pkg::ST_ADDR_HI) begin
        addr_hi_reg <= rx_byte;
      end
      if (byte_done && state_reg == eeprom_front_end_pkg::ST_ADDR_LO) begin
        O_ADDR <= {addr_hi_reg, rx_byte};
      end
    end
  end

  // Data strobes only go to the core when unprotected; O_DATA takes every data byte
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_DATA       <= eeprom_front_end_pkg::BYTE_RESET;
      O_DATA_VALID <= 1'b0;
    end else begin
      O_DATA_VALID <= byte_done & ~protect &
                      (state_reg == eeprom_front_end_pkg::ST_WR_DATA);
      if (byte_done && state_reg == eeprom_front_end_pkg::ST_WR_DATA) begin
        O_DATA <= rx_byte;
      end
    end
  end

  // Read request on select match and on each master ack; load one cycle later
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_READ_REQ <= 1'b0;
      load_reg   <= 1'b0;
      tx_reg     <= eeprom_front_end_pkg::BYTE_RESET;
    end else begin
      O_READ_REQ <= (byte_done & (state_reg == eeprom_front_end_pkg::ST_DEVSEL) &
                     (state_next == eeprom_front_end_pkg::ST_RD_DATA)) |
                    // Ack flag high marks the select's own ack slot, not a master ack
                    (ack_rise & (state_reg == eeprom_front_end_pkg::ST_RD_DATA) &
                     ~ack_reg & ~link_bit_reg & ~start_ev & ~stop_ev);
      load_reg   <= O_READ_REQ;
      if (load_reg) begin
        tx_reg <= I_READ_DATA;
      end
    end
  end

  // Write trigger only for a stop right after an acked data byte; the
  // stop's own clock rise is counted, so the slot flag spans two rises
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      wr_slot_reg   <= 1'b0;
      O_WRITE_START <= 1'b0;
    end else begin
      O_WRITE_START <= stop_ev & wr_slot_reg & (cnt_reg == eeprom_front_end_pkg::BIT_SECOND);
      if (start_ev || stop_ev) begin
        wr_slot_reg <= 1'b0;
      end else if (ack_rise) begin
        wr_slot_reg <= ack_reg & (state_reg == eeprom_front_end_pkg::ST_WR_DATA);
      end else if (rise_ev && cnt_reg == eeprom_front_end_pkg::BIT_SECOND) begin
        wr_slot_reg <= 1'b0;
      end
    end
  end

  // Open-drain pad: output level fixed low, enable pulls the line
  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_SDA_OUT <= 1'b0;
      O_SDA_OE  <= 1'b0;
      O_STANDBY <= 1'b1;
    end else begin
      O_SDA_OUT <= 1'b0;
      O_SDA_OE  <= oe_next;
      O_STANDBY <= (state_next == eeprom_front_end_pkg::ST_STANDBY) & ~I_WRITE_BUSY;
    end
  end

endmodule : eeprom_front_end

`default_nettype wire

// file: verilog/eeprom_front_end_pkg.sv
`default_nettype none

package eeprom_front_end_pkg;

  // Bit counter values within one nine-clock byte frame
  localparam logic [3:0] BIT_FIRST     = 4'h0;
  localparam logic [3:0] BIT_SECOND    = 4'h1;
  localparam logic [3:0] BIT_LAST_DATA = 4'h7;
  localparam logic [3:0] BIT_ACK_SLOT  = 4'h8;

  // Select byte field layout
  localparam int SEL_TYPE_MSB = 7;
  localparam int SEL_TYPE_LSB = 4;
  localparam int SEL_CHIP_MSB = 3;
  localparam int SEL_CHIP_LSB = 1;
  localparam int SEL_RW_BIT   = 0;

  // Read/write flag encoding
  localparam logic RW_READ  = 1'b1;
  localparam logic RW_WRITE = 1'b0;

  // Values after reset
  localparam logic [7:0]  BYTE_RESET = 8'h00;
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [3:0]  CNT_RESET  = 4'h0;

  // Bus protocol states, one-hot
  typedef enum logic [6:0] {
    ST_STANDBY = 7'b000_0001,
    ST_DEVSEL  = 7'b000_0010,
    ST_ADDR_HI = 7'b000_0100,
    ST_ADDR_LO = 7'b000_1000,
    ST_WR_DATA = 7'b001_0000,
    ST_RD_DATA = 7'b010_0000,
    ST_IGNORE  = 7'b100_0000
  } bus_state_type;

endpackage : eeprom_front_end_pkg

`default_nettype wire
